// ---- logic/cpwt_timer.sv ----
// cascaded 16-bit pulse generator and warm-up counter with wishbone registers
// assumes one 20 MHz clock, a classic wishbone master and async pins for count inputs
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cpwt_defines.svh"

// How it works
// - two byte stages form one 16-bit up-counter
// - pulse-width match toggles flop, counting continues
// - period match toggles flop, clears counter
// - period match raises the match interrupt
// - flop loads initial bit on upper control writes while stopped; reset clears it
// - pulse pin is inverse of flop
// - compare values act at once, unbuffered
// - stopped timer holds pulse pin level
// - run is bit 3, initial bit 7
// - warm-up compares only upper period byte
// - warm-up match clears counter, raises interrupt
// - sources derive from high and low clocks and the external count pin
module cpwt_timer (
  input  wire logic                   clk,             // 20 MHz system clock
  input  wire logic                   reset,           // async, active high
  input  wire logic                   wb_cyc_i,        // bus cycle
  input  wire logic                   wb_stb_i,        // strobe
  input  wire logic                   wb_we_i,         // write enable
  input  wire logic [7:0]             wb_adr_i,        // byte address
  input  wire logic [3:0]             wb_sel_i,        // byte lanes
  input  wire logic [31:0]            wb_dat_i,        // write data
  output logic      [31:0]            wb_dat_o,        // read data
  output logic                        wb_ack_o,        // acknowledge
  input  wire logic                   lowFreqClock,    // subsidiary oscillator pin
  input  wire logic                   extCountIn,      // external count pin
  output logic                        pulseOutputPin,  // inverse of output flop
  output logic                        timerMatchIrq,   // one-cycle match pulse
  output cpwt_pkg::cpwt_mode_type     timerMode        // current mode
);
  import cpwt_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  lowerStageControl;
  logic [7:0]  upperStageControl;
  logic [7:0]  pulseWidthCompareLow;
  logic [7:0]  pulseWidthCompareHigh;
  logic [7:0]  periodCompareLow;
  logic [7:0]  periodCompareHigh;
  logic [15:0] count;
  logic        outputFlop;
  logic [4:0]  prescale;
  logic        lowSync1;
  logic        lowSync2;
  logic        lowPrev;
  logic        extSync1;
  logic        extSync2;
  logic        extPrev;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire         busReq      = wb_cyc_i & wb_stb_i;
  wire         busWrite    = busReq & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire         hitLowerCtl = wb_adr_i == `CPWT_OFS_LOWER_CTRL;
  wire         hitUpperCtl = wb_adr_i == `CPWT_OFS_UPPER_CTRL;
  wire         hitPwLow    = wb_adr_i == `CPWT_OFS_PW_LOW;
  wire         hitPwHigh   = wb_adr_i == `CPWT_OFS_PW_HIGH;
  wire         hitPerLow   = wb_adr_i == `CPWT_OFS_PER_LOW;
  wire         hitPerHigh  = wb_adr_i == `CPWT_OFS_PER_HIGH;
  wire         hitStatus   = wb_adr_i == `CPWT_OFS_STATUS;
  wire         wrUpperCtl  = busWrite & hitUpperCtl;
  wire         wrLowerCtl  = busWrite & hitLowerCtl;
  wire         wrPwLow     = busWrite & hitPwLow;
  wire         wrPwHigh    = busWrite & hitPwHigh;
  wire         wrPerLow    = busWrite & hitPerLow;
  wire         wrPerHigh   = busWrite & hitPerHigh;
  wire [7:0]   wrByte      = wb_dat_i[7:0];

  // ****************************************************************
  // control fields
  // ****************************************************************
  wire         runBit      = upperStageControl[`CPWT_UPPER_RUN_BIT];
  wire         initBit     = upperStageControl[`CPWT_UPPER_INIT_BIT];
  wire         nextInit    = wrByte[`CPWT_UPPER_INIT_BIT];
  wire [2:0]   sourceSel   = lowerStageControl[`CPWT_LOWER_SRC_MSB:`CPWT_LOWER_SRC_LSB];
  wire         warmupSel   = upperStageControl[`CPWT_UPPER_MODE_BIT];
  wire [15:0]  pulseWidth  = {pulseWidthCompareHigh, pulseWidthCompareLow};
  wire [15:0]  period      = {periodCompareHigh, periodCompareLow};

  assign timerMode = warmupSel ? CPWT_WARMUP : CPWT_PULSE;

  // ****************************************************************
  // source clock tick selection
  // ****************************************************************
  wire         lowRise     = lowSync2 & ~lowPrev;
  wire         extRise     = extSync2 & ~extPrev;
  logic        tick;

  always_comb begin
    unique case (sourceSel)
      `CPWT_SRC_CLK:      tick = 1'b1;
      `CPWT_SRC_DIV2:     tick = prescale[0];
      `CPWT_SRC_DIV8:     tick = &prescale[2:0];
      `CPWT_SRC_DIV32:    tick = &prescale;
      `CPWT_SRC_LOWFREQ:  tick = lowRise;
      `CPWT_SRC_EXTERNAL: tick = extRise;
      default:            tick = 1'b0;
    endcase
  end

  // ****************************************************************
  // compare detection
  // ****************************************************************
  wire         step        = runBit & tick;
  wire         pulseMode   = timerMode == CPWT_PULSE;
  wire         pwHit       = step & pulseMode & (count == pulseWidth);
  wire         perHitPulse = step & pulseMode & (count == period);
  wire         perHitWarm  = step & ~pulseMode &
                             (count[15:8] == periodCompareHigh);
  wire         periodHit   = perHitPulse | perHitWarm;
  wire         loadInit    = wrUpperCtl & ~runBit;
  wire         nextFlop    = loadInit ? nextInit
                                      : outputFlop ^ (pwHit ^ perHitPulse);
  wire [15:0]  nextCount   = !runBit   ? `CPWT_RST_COUNT
                           : periodHit ? `CPWT_RST_COUNT
                           : step      ? count + 16'h0001
                           : count;

  // ****************************************************************
  // pin synchronisers and prescaler
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lowSync1 <= 1'b0;
      lowSync2 <= 1'b0;
      lowPrev  <= 1'b0;
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extPrev  <= 1'b0;
      prescale <= 5'h00;
    end else begin
      lowSync1 <= lowFreqClock;
      lowSync2 <= lowSync1;
      lowPrev  <= lowSync2;
      extSync1 <= extCountIn;
      extSync2 <= extSync1;
      extPrev  <= extSync2;
      prescale <= prescale + 5'h01;
    end
  end

  // ****************************************************************
  // counter, output flop and match pulse
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count         <= `CPWT_RST_COUNT;
      outputFlop    <= 1'b0;
      timerMatchIrq <= 1'b0;
    end else begin
      count         <= nextCount;
      outputFlop    <= nextFlop;
      timerMatchIrq <= periodHit;
    end
  end

  assign pulseOutputPin = ~outputFlop;

  // ****************************************************************
  // register writes
  // ****************************************************************
  cpwt_byte_reg #(
    .WIDTH       (8),
    .RESET_VALUE (`CPWT_RST_CTRL)
  ) u_cpwt_byte_reg_lower_ctrl (
    .clk       (clk),
    .reset     (reset),
    .writeEn   (wrLowerCtl),
    .writeData (wrByte),
    .value     (lowerStageControl)
  );

  cpwt_byte_reg #(
    .WIDTH       (8),
    .RESET_VALUE (`CPWT_RST_CTRL)
  ) u_cpwt_byte_reg_upper_ctrl (
    .clk       (clk),
    .reset     (reset),
    .writeEn   (wrUpperCtl),
    .writeData (wrByte),
    .value     (upperStageControl)
  );

  cpwt_byte_reg #(
    .WIDTH       (8),
    .RESET_VALUE (`CPWT_RST_CMP)
  ) u_cpwt_byte_reg_pw_low (
    .clk       (clk),
    .reset     (reset),
    .writeEn   (wrPwLow),
    .writeData (wrByte),
    .value     (pulseWidthCompareLow)
  );

  cpwt_byte_reg #(
    .WIDTH       (8),
    .RESET_VALUE (`CPWT_RST_CMP)
  ) u_cpwt_byte_reg_pw_high (
    .clk       (clk),
    .reset     (reset),
    .writeEn   (wrPwHigh),
    .writeData (wrByte),
    .value     (pulseWidthCompareHigh)
  );

  cpwt_byte_reg #(
    .WIDTH       (8),
    .RESET_VALUE (`CPWT_RST_CMP)
  ) u_cpwt_byte_reg_per_low (
    .clk       (clk),
    .reset     (reset),
    .writeEn   (wrPerLow),
    .writeData (wrByte),
    .value     (periodCompareLow)
  );

  cpwt_byte_reg #(
    .WIDTH       (8),
    .RESET_VALUE (`CPWT_RST_CMP)
  ) u_cpwt_byte_reg_per_high (
    .clk       (clk),
    .reset     (reset),
    .writeEn   (wrPerHigh),
    .writeData (wrByte),
    .value     (periodCompareHigh)
  );

  // ****************************************************************
  // read mux and acknowledge
  // ****************************************************************
  logic [31:0] readMux;
  logic [31:0] statusWord;

  always_comb begin
    statusWord                      = {16'h0000, count};
    statusWord[`CPWT_STAT_FLOP_BIT] = outputFlop;
    statusWord[`CPWT_STAT_PIN_BIT]  = ~outputFlop;
    statusWord[`CPWT_STAT_RUN_BIT]  = runBit;
  end

  always_comb begin
    readMux = 32'h00000000;
    if (hitLowerCtl) readMux = {24'h000000, lowerStageControl};
    if (hitUpperCtl) readMux = {24'h000000, upperStageControl};
    if (hitPwLow)    readMux = {24'h000000, pulseWidthCompareLow};
    if (hitPwHigh)   readMux = {24'h000000, pulseWidthCompareHigh};
    if (hitPerLow)   readMux = {24'h000000, periodCompareLow};
    if (hitPerHigh)  readMux = {24'h000000, periodCompareHigh};
    if (hitStatus)   readMux = statusWord;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
      wb_dat_o <= (busReq & ~wb_ack_o) ? readMux : 32'h00000000;
    end
  end

endmodule

// ****************************************************************
// one software register with its own write strobe
// ****************************************************************
module cpwt_byte_reg #(
  parameter int               WIDTH       = 8,   // bits held
  parameter logic [WIDTH-1:0] RESET_VALUE = '0   // contents after reset
) (
  input  wire logic             clk,        // system clock
  input  wire logic             reset,      // async, active high
  input  wire logic             writeEn,    // bus write selects this register
  input  wire logic [WIDTH-1:0] writeData,  // new contents
  output logic      [WIDTH-1:0] value       // current contents
);

  // ****************************************************************
  // storage
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      value <= RESET_VALUE;
    end else if (writeEn) begin
      value <= writeData;
    end
  end

endmodule
`default_nettype wire

// ---- shared/cpwt_defines.svh ----
// register offsets, field positions, source select codes and reset values of the cascaded timer
// assumes inclusion by bare name from the timer module, its bound checker and the bench
`ifndef CPWT_DEFINES_SVH
`define CPWT_DEFINES_SVH

// ****************************************************************
// register byte offsets on the wishbone bus
// ****************************************************************
`define CPWT_OFS_LOWER_CTRL   8'h00
`define CPWT_OFS_UPPER_CTRL   8'h04
`define CPWT_OFS_PW_LOW       8'h08
`define CPWT_OFS_PW_HIGH      8'h0c
`define CPWT_OFS_PER_LOW      8'h10
`define CPWT_OFS_PER_HIGH     8'h14
`define CPWT_OFS_STATUS       8'h18

// ****************************************************************
// field positions
// ****************************************************************
`define CPWT_UPPER_INIT_BIT   7
`define CPWT_UPPER_RUN_BIT    3
`define CPWT_UPPER_MODE_BIT   0
`define CPWT_LOWER_INIT_BIT   7
`define CPWT_LOWER_SRC_LSB    0
`define CPWT_LOWER_SRC_MSB    2
`define CPWT_STAT_FLOP_BIT    16
`define CPWT_STAT_PIN_BIT     17
`define CPWT_STAT_RUN_BIT     18

// ****************************************************************
// source select codes
// ****************************************************************
`define CPWT_SRC_CLK          3'h0
`define CPWT_SRC_DIV2         3'h1
`define CPWT_SRC_DIV8         3'h2
`define CPWT_SRC_DIV32        3'h3
`define CPWT_SRC_LOWFREQ      3'h4
`define CPWT_SRC_EXTERNAL     3'h5

// ****************************************************************
// reset values
// ****************************************************************
`define CPWT_RST_CTRL         8'h00
`define CPWT_RST_CMP          8'hff
`define CPWT_RST_COUNT        16'h0000

`endif

// ---- shared/cpwt_pkg.sv ----
// types shared by the cascaded pulse and warm-up timer
// assumes the defines header sits beside it on the include path
package cpwt_pkg;

  // ****************************************************************
  // operating mode of the cascaded counter
  // ****************************************************************
  typedef enum logic {
    CPWT_PULSE,
    CPWT_WARMUP
  } cpwt_mode_type;

endpackage

// ---- testbench/cpwt_timer_assertions.sv ----
// port-level checks of the cascaded timer, bound into cpwt_timer
// assumes classic wishbone single cycles from the master
`timescale 1ns/1ps
`default_nettype none
`include "cpwt_defines.svh"
module cpwt_timer_assertions
  import cpwt_pkg::*;
(
  input wire logic                   clk,            // clock
  input wire logic                   reset,          // async reset
  input wire logic                   wb_cyc_i,       // cycle
  input wire logic                   wb_stb_i,       // strobe
  input wire logic                   wb_we_i,        // write
  input wire logic [7:0]             wb_adr_i,       // address
  input wire logic [3:0]             wb_sel_i,       // lanes
  input wire logic [31:0]            wb_dat_i,       // write data
  input wire logic [31:0]            wb_dat_o,       // read data
  input wire logic                   wb_ack_o,       // acknowledge
  input wire logic                   lowFreqClock,   // slow source
  input wire logic                   extCountIn,     // count pin
  input wire logic                   pulseOutputPin, // pulse pin
  input wire logic                   timerMatchIrq,  // match pulse
  input wire cpwt_pkg::cpwt_mode_type timerMode      // mode
);
  logic runBit;
  wire  upperWr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `CPWT_OFS_UPPER_CTRL;
  // ****************************************************************
  // run bit as software last wrote it
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      runBit <= 1'b0;
    end else if (upperWr) begin
      runBit <= wb_dat_i[`CPWT_UPPER_RUN_BIT];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > `CPWT_OFS_STATUS |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  irq_pulse_a: assert property (timerMatchIrq |=> !timerMatchIrq) else $error("irq wider than one cycle");
  irq_stopped_a: assert property (!runBit && !$past(runBit) && !$past(runBit, 2) |-> !timerMatchIrq)
    else $error("irq while stopped");
  flop_load_a: assert property (upperWr && !runBit |=> pulseOutputPin == !$past(wb_dat_i[7]))
    else $error("pin not loaded from initial bit");
  warmup_flop_a: assert property (timerMatchIrq && timerMode == CPWT_WARMUP |-> $stable(pulseOutputPin))
    else $error("warm-up match moved pin");
  mode_follow_a: assert property (upperWr |=> timerMode == cpwt_mode_type'($past(wb_dat_i[0])))
    else $error("mode not taken");
  stop_hold_a: assert property (!runBit && !upperWr |=> $stable(pulseOutputPin))
    else $error("pin moved while stopped");
  cover property (timerMatchIrq && timerMode == CPWT_PULSE);
  cover property (timerMatchIrq && timerMode == CPWT_WARMUP);
  cover property (upperWr && !runBit);
endmodule
bind cpwt_timer cpwt_timer_assertions u_cpwt_timer_assertions (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lowFreqClock(lowFreqClock), .extCountIn(extCountIn),
  .pulseOutputPin(pulseOutputPin), .timerMatchIrq(timerMatchIrq), .timerMode(timerMode));
`default_nettype wire

// ---- testbench/test_cpwt_timer.sv ----
// self-checking bench of the cascaded timer
// assumes the timer and its bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cpwt_defines.svh"
module test_cpwt_timer;
  import cpwt_pkg::*;
  logic          clk, reset, cyc, stb, we, pin, irq, ack;
  logic          lowFreqClock = 1'b0;
  logic          extCountIn   = 1'b0;
  logic [7:0]    adr;
  logic [3:0]    sel;
  logic [31:0]   wdat, rdat;
  logic [31:0]   expQ[$];
  cpwt_mode_type mode;
  int            bad_count, n_compared, seed, n, s, ph;
  int            divs[6] = '{1, 2, 8, 32, 12, 8};
  cpwt_timer u_cpwt_timer (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .lowFreqClock(lowFreqClock), .extCountIn(extCountIn), .pulseOutputPin(pin),
    .timerMatchIrq(irq), .timerMode(mode));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // count pin rises every 8 cycles, slow source every 12
  always @(posedge clk) begin
    ph <= ph + 1;
    if (ph % 4 == 3) extCountIn <= ~extCountIn;
    if (ph % 6 == 5) lowFreqClock <= ~lowFreqClock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    if (!w) expQ.push_back(d);
    @(posedge clk);
    while (!ack) @(posedge clk);
    {cyc, stb} <= 2'b00;
  endtask
  always @(posedge clk) if (ack && !we) chk(rdat, expQ.pop_front());
  task automatic setCmp(input logic [7:0] a, input logic [15:0] v);
    bus(1'b1, a, {24'h0, v[7:0]});
    bus(1'b1, a + 8'h04, {24'h0, v[15:8]});
  endtask
  task automatic waitIrq(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (!irq && cnt < 3000);
  endtask
  // ****************************************************************
  // one pulse run: spacing, width, stop hold, forced level
  // ****************************************************************
  task automatic runPulse(input logic [2:0] src, input logic [15:0] pw, input logic [15:0] per);
    int   k;
    logic held;
    setCmp(`CPWT_OFS_PW_LOW, pw);
    setCmp(`CPWT_OFS_PER_LOW, per);
    bus(1'b1, `CPWT_OFS_LOWER_CTRL, {29'h0, src});
    bus(1'b1, `CPWT_OFS_UPPER_CTRL, 32'h88);
    waitIrq(k);
    waitIrq(k);
    chk(32'(k), 32'((per + 1) * divs[src]));
    while (pin !== 1'b0) @(negedge clk);
    while (pin !== 1'b1) @(negedge clk);
    k = 0;
    while (pin === 1'b1) begin
      @(negedge clk);
      k++;
    end
    chk(32'(k), 32'((per - pw) * divs[src]));
    bus(1'b1, `CPWT_OFS_UPPER_CTRL, 32'h00);
    repeat (3) @(negedge clk);
    held = pin;
    repeat (40) @(negedge clk);
    chk({31'h0, pin}, {31'h0, held});
    bus(1'b1, `CPWT_OFS_UPPER_CTRL, 32'h00);
    @(negedge clk);
    chk({31'h0, pin}, 32'h1);
  endtask
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    test_done();
  end
  initial begin
    seed = 85040;
    {cyc, stb, we, adr, wdat} = '0;
    reset = 1'b1;
    sel = 4'h1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    bus(1'b0, `CPWT_OFS_LOWER_CTRL, 32'h0);
    bus(1'b0, `CPWT_OFS_UPPER_CTRL, 32'h0);
    for (s = 0; s < 4; s++) bus(1'b0, `CPWT_OFS_PW_LOW + 8'(4 * s), 32'hff);
    bus(1'b0, 8'h1c, 32'h0);
    sel <= 4'h0;
    bus(1'b1, `CPWT_OFS_PW_LOW, 32'h12);
    sel <= 4'h1;
    bus(1'b0, `CPWT_OFS_PW_LOW, 32'hff);
    bus(1'b0, `CPWT_OFS_STATUS, 32'h20000);
    chk({31'h0, pin}, 32'h1);
    for (s = 0; s < 6; s++) runPulse(3'(s), 16'h0001, 16'h0003);
    repeat (3) runPulse(3'h0, 16'(2 + ($random(seed) & 3)), 16'(8 + ($random(seed) & 7)));
    // warm-up: low period byte must be ignored
    setCmp(`CPWT_OFS_PER_LOW, 16'h0255);
    bus(1'b1, `CPWT_OFS_LOWER_CTRL, 32'h0);
    bus(1'b1, `CPWT_OFS_UPPER_CTRL, 32'h01);
    bus(1'b1, `CPWT_OFS_UPPER_CTRL, 32'h09);
    waitIrq(n);
    waitIrq(n);
    chk(32'(n), 32'h201);
    chk({31'h0, pin}, 32'h1);
    bus(1'b1, `CPWT_OFS_UPPER_CTRL, 32'h01);
    bus(1'b0, `CPWT_OFS_STATUS, 32'h20000);
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire
